// *** include/iqcap_pkg.sv ***
// What this block does
// - Trigger low holds sample counters cleared
// - First edge: write low, addressing blocked, ready high
// - RAM address from registered counter copy
// - Sample clock and bank enables toggle after arming
// - Counter steps 0 to 4095 on sample clock
// - New conversion; previous byte stored each step
// - Carry stops toggling; clock and enables high
// - Write select rises after last byte written
// - Capture end opens processor addressing
// - Ready low until processor reads sample RAM
// - Odd address read enables quadrature bank
// - Even address read enables in-phase bank
// - Samples are 8-bit two's complement
// - Low byte cleared during sample RAM reads
// - Sequencer runs on the system clock
`default_nettype none
package iqcap_pkg;
  localparam int unsigned    IQCAP_CLK_PERIOD_NS = 40;
  localparam int unsigned    IQCAP_SAMPLE_W      = 8;
  localparam int unsigned    IQCAP_ADDR_W        = 12;
  localparam int unsigned    IQCAP_DEPTH         = 4096;
  localparam int unsigned    IQCAP_STAGE_W       = 4;
  localparam int unsigned    IQCAP_STAGES        = 3;
  localparam logic [11:0]    IQCAP_ADDR_FIRST    = 12'h0000;
  localparam logic [11:0]    IQCAP_ADDR_LAST     = 12'h0fff;
  localparam logic [7:0]     IQCAP_SAMPLE_MIN    = 8'h80;
  localparam logic [7:0]     IQCAP_SAMPLE_MAX    = 8'h7f;
  localparam logic [7:0]     IQCAP_SAMPLE_RESET  = 8'h00;
  localparam logic           IQCAP_WRSEL_RESET   = 1'b1;
  localparam logic           IQCAP_HOSTEN_RESET  = 1'b0;
  localparam logic           IQCAP_READY_RESET   = 1'b1;
  localparam logic           IQCAP_SCLK_RESET    = 1'b1;

  typedef enum logic [2:0] {
    IQCAP_ST_IDLE,
    IQCAP_ST_ARMED,
    IQCAP_ST_RUN,
    IQCAP_ST_LAST,
    IQCAP_ST_FLUSH,
    IQCAP_ST_DONE
  } iqcap_state_e;
endpackage
`default_nettype wire

// *** include/iqcap_count_if.sv ***
`default_nettype none
interface iqcap_count_if;
  logic        clear;
  logic        step;
  logic [11:0] count;
  logic        carry;

  modport ctl (output clear, output step, input count, input carry);
  modport cnt (input clear, input step, output count, output carry);
endinterface
`default_nettype wire

// *** src/iqcap_sample_counter.sv ***
`default_nettype none
module iqcap_sample_counter (
  input  wire logic      mclk_in,
  input  wire logic      reset_n_in,
  iqcap_count_if.cnt     cnt_if
);
  localparam int unsigned SW = iqcap_pkg::IQCAP_STAGE_W;

  logic [11:0] count;
  logic [11:0] next_count;
  logic [3:0]  stage_en;

  assign stage_en[0] = cnt_if.step;

  // Cascaded stages, each ripples its carry into the next
  genvar g;
  generate
    for (g = 0; g < iqcap_pkg::IQCAP_STAGES; g++) begin : g_stage
      wire logic [SW-1:0] slice = count[g*SW +: SW];
      assign stage_en[g+1] = stage_en[g] & (&slice);
      assign next_count[g*SW +: SW] = cnt_if.clear ? '0
                                    : (stage_en[g] ? SW'(slice + 1'b1) : slice);
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= iqcap_pkg::IQCAP_ADDR_FIRST;
    end else begin
      count <= next_count;
    end
  end

  assign cnt_if.count = count;
  assign cnt_if.carry = (count == iqcap_pkg::IQCAP_ADDR_LAST);
endmodule // iqcap_sample_counter
`default_nettype wire

// *** src/iqcap_sequencer.sv ***
`default_nettype none
module iqcap_sequencer (
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic       capture_trigger_n_in,
  input  wire logic [7:0] adc_inphase_in,
  input  wire logic [7:0] adc_quadrature_in,
  input  wire logic       host_addr_a15_in,
  input  wire logic       host_addr_a14_in,
  input  wire logic       host_addr_a0_in,
  input  wire logic       data_space_select_n_in,
  input  wire logic       external_cycle_strobe_n_in,
  output logic            sample_clock_out,
  output logic            inphase_bank_enable_n_out,
  output logic            quadrature_bank_enable_n_out,
  output logic            sample_write_select_n_out,
  output logic            host_address_enable_out,
  output logic            capture_ready_n_out,
  output logic            low_byte_clear_out,
  output logic            counter_terminal_carry_out,
  output logic [11:0]     ram_address_out,
  output logic [7:0]      ram_inphase_data_out,
  output logic [7:0]      ram_quadrature_data_out
);
  iqcap_count_if cnt_if ();

  iqcap_sample_counter u_counter (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .cnt_if     (cnt_if)
  );

  // Pin synchronisers; the first stage feeds only the second
  logic       capture_trigger_n_meta;
  logic       capture_trigger_n_sync;
  logic [4:0] bus_meta;
  logic [4:0] bus_sync;
  logic [7:0] adc_i_meta;
  logic [7:0] adc_i_sync;
  logic [7:0] adc_q_meta;
  logic [7:0] adc_q_sync;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      capture_trigger_n_meta  <= 1'b1;
      capture_trigger_n_sync  <= 1'b1;
      bus_meta   <= 5'h03;
      bus_sync   <= 5'h03;
      adc_i_meta <= iqcap_pkg::IQCAP_SAMPLE_RESET;
      adc_i_sync <= iqcap_pkg::IQCAP_SAMPLE_RESET;
      adc_q_meta <= iqcap_pkg::IQCAP_SAMPLE_RESET;
      adc_q_sync <= iqcap_pkg::IQCAP_SAMPLE_RESET;
    end else begin
      capture_trigger_n_meta  <= capture_trigger_n_in;
      capture_trigger_n_sync  <= capture_trigger_n_meta;
      bus_meta   <= {host_addr_a15_in, host_addr_a14_in, host_addr_a0_in,
                     data_space_select_n_in, external_cycle_strobe_n_in};
      bus_sync   <= bus_meta;
      adc_i_meta <= adc_inphase_in;
      adc_i_sync <= adc_i_meta;
      adc_q_meta <= adc_quadrature_in;
      adc_q_sync <= adc_q_meta;
    end
  end

  iqcap_pkg::iqcap_state_e state;
  iqcap_pkg::iqcap_state_e next_state;

  logic       sample_clock;
  logic       write_sel_n;
  logic       host_en;
  logic       ready_n;
  logic [7:0] conv_i;
  logic [7:0] conv_q;
  logic       next_sample_clock;
  logic       next_write_sel_n;
  logic       next_host_en;
  logic       next_ready_n;

  // Processor read decode
  wire logic a15       = bus_sync[4];
  wire logic a14       = bus_sync[3];
  wire logic a0        = bus_sync[2];
  wire logic ds_n      = bus_sync[1];
  wire logic external_cycle_strobe_n_n    = bus_sync[0];
  wire logic read_hit  = a15 & ~a14 & ~ds_n & ~external_cycle_strobe_n_n;
  wire logic in_done   = (state == iqcap_pkg::IQCAP_ST_DONE);
  wire logic read_q    = in_done & read_hit & a0;
  wire logic read_i    = in_done & read_hit & ~a0;
  wire logic toggling  = (state == iqcap_pkg::IQCAP_ST_ARMED) |
                         (state == iqcap_pkg::IQCAP_ST_RUN);
  // Sample clock about to rise: one sample per two system clocks
  wire logic step_rise = toggling & ~sample_clock;
  wire logic capturing = (next_state != iqcap_pkg::IQCAP_ST_IDLE) &
                         (next_state != iqcap_pkg::IQCAP_ST_DONE);

  assign cnt_if.clear = ~capture_trigger_n_sync;
  assign cnt_if.step  = step_rise & (state == iqcap_pkg::IQCAP_ST_RUN);

  always_comb begin
    next_state = state;
    case (state)
      iqcap_pkg::IQCAP_ST_IDLE:  next_state = state;
      iqcap_pkg::IQCAP_ST_ARMED: begin
        if (capture_trigger_n_sync) begin
          next_state = iqcap_pkg::IQCAP_ST_RUN;
        end
      end
      iqcap_pkg::IQCAP_ST_RUN: begin
        if (step_rise && cnt_if.carry) begin
          next_state = iqcap_pkg::IQCAP_ST_LAST;
        end
      end
      iqcap_pkg::IQCAP_ST_LAST:  next_state = iqcap_pkg::IQCAP_ST_FLUSH;
      iqcap_pkg::IQCAP_ST_FLUSH: next_state = iqcap_pkg::IQCAP_ST_DONE;
      iqcap_pkg::IQCAP_ST_DONE:  next_state = state;
      default:                   next_state = iqcap_pkg::IQCAP_ST_IDLE;
    endcase
    // A new trigger restarts from any state
    if (!capture_trigger_n_sync) begin
      next_state = iqcap_pkg::IQCAP_ST_ARMED;
    end
  end

  // Only the flush cycle drops the clock after the carry, for the last write
  assign next_sample_clock = toggling ? ~sample_clock
                           : (state != iqcap_pkg::IQCAP_ST_LAST);
  assign next_write_sel_n  = ~capturing;
  assign next_host_en      = capturing;
  // Trigger forces ready high; a read in the done state also releases it
  assign next_ready_n      = (next_state == iqcap_pkg::IQCAP_ST_ARMED) ? 1'b1
                           : (state == iqcap_pkg::IQCAP_ST_FLUSH) ? 1'b0
                           : (in_done && read_hit) ? 1'b1
                           : ready_n;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state        <= iqcap_pkg::IQCAP_ST_IDLE;
      sample_clock <= iqcap_pkg::IQCAP_SCLK_RESET;
      write_sel_n  <= iqcap_pkg::IQCAP_WRSEL_RESET;
      host_en      <= iqcap_pkg::IQCAP_HOSTEN_RESET;
      ready_n      <= iqcap_pkg::IQCAP_READY_RESET;
    end else begin
      // Every register in this block runs straight off the system clock, no enable; the pipeline below steps on step_rise
      state        <= next_state;
      sample_clock <= next_sample_clock;
      write_sel_n  <= next_write_sel_n;
      host_en      <= next_host_en;
      ready_n      <= next_ready_n;
    end
  end

  // One-deep pipeline: latch new conversion, present previous one for write
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      conv_i                  <= iqcap_pkg::IQCAP_SAMPLE_RESET;
      conv_q                  <= iqcap_pkg::IQCAP_SAMPLE_RESET;
      ram_inphase_data_out    <= iqcap_pkg::IQCAP_SAMPLE_RESET;
      ram_quadrature_data_out <= iqcap_pkg::IQCAP_SAMPLE_RESET;
      ram_address_out         <= iqcap_pkg::IQCAP_ADDR_FIRST;
    end else if (step_rise) begin
      conv_i                  <= adc_i_sync;
      conv_q                  <= adc_q_sync;
      ram_inphase_data_out    <= conv_i;
      ram_quadrature_data_out <= conv_q;
      ram_address_out         <= cnt_if.count;
    end
  end

  // Bank enables follow the sample clock while writing, decode while reading
  assign inphase_bank_enable_n_out    = in_done ? ~read_i : sample_clock;
  assign quadrature_bank_enable_n_out = in_done ? ~read_q : sample_clock;
  assign low_byte_clear_out           = read_i | read_q;
  assign sample_clock_out             = sample_clock;
  assign sample_write_select_n_out    = write_sel_n;
  assign host_address_enable_out      = host_en;
  assign capture_ready_n_out          = ready_n;
  assign counter_terminal_carry_out   = cnt_if.carry;

  // Checks
  property p_clear_on_trigger;
    @(posedge mclk_in) disable iff (!reset_n_in)
      !capture_trigger_n_sync |=> (cnt_if.count == iqcap_pkg::IQCAP_ADDR_FIRST);
  endproperty
  a_clear_on_trigger: assert property (p_clear_on_trigger)
    else $error("counter not cleared while trigger low");

  property p_arm_outputs;
    @(posedge mclk_in) disable iff (!reset_n_in)
      !capture_trigger_n_sync |=> (!sample_write_select_n_out && host_address_enable_out
                      && capture_ready_n_out);
  endproperty
  a_arm_outputs: assert property (p_arm_outputs)
    else $error("arming outputs wrong after trigger");

  property p_addr_copy;
    @(posedge mclk_in) disable iff (!reset_n_in)
      step_rise |=> (ram_address_out == $past(cnt_if.count));
  endproperty
  a_addr_copy: assert property (p_addr_copy)
    else $error("ram address not registered counter copy");

  property p_toggle;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (state == iqcap_pkg::IQCAP_ST_RUN) ##1 (state == iqcap_pkg::IQCAP_ST_RUN)
        |-> (sample_clock_out != $past(sample_clock_out))
            && (inphase_bank_enable_n_out == sample_clock_out);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("sample clock not toggling in run");

  property p_count_step;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (cnt_if.step && !cnt_if.carry && capture_trigger_n_sync)
        |=> (cnt_if.count == 12'($past(cnt_if.count) + 1'b1));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step by one");

  property p_pipeline;
    @(posedge mclk_in) disable iff (!reset_n_in)
      step_rise ##2 step_rise |=> (ram_inphase_data_out == $past(adc_i_sync, 3))
                                  && (ram_quadrature_data_out == $past(adc_q_sync, 3));
  endproperty
  a_pipeline: assert property (p_pipeline)
    else $error("stored byte is not previous conversion");

  property p_stop_high;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (state == iqcap_pkg::IQCAP_ST_RUN && step_rise && cnt_if.carry && capture_trigger_n_sync)
        |=> sample_clock_out ##1 !sample_clock_out ##1 sample_clock_out [*3];
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("sample clock not held high after carry");

  property p_write_release;
    @(posedge mclk_in) disable iff (!reset_n_in)
      $rose(sample_write_select_n_out)
        |-> ($past(state) == iqcap_pkg::IQCAP_ST_FLUSH) && !host_address_enable_out
            && !capture_ready_n_out;
  endproperty
  a_write_release: assert property (p_write_release)
    else $error("write select rose before final write");

  property p_host_open;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (state == iqcap_pkg::IQCAP_ST_DONE) |-> !host_address_enable_out;
  endproperty
  a_host_open: assert property (p_host_open)
    else $error("processor addressing still blocked");

  property p_ready_hold;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (in_done && !capture_ready_n_out && !read_hit && capture_trigger_n_sync)
        |=> !capture_ready_n_out;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready released without a read");

  property p_ready_release;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (in_done && read_hit) |=> capture_ready_n_out;
  endproperty
  a_ready_release: assert property (p_ready_release)
    else $error("ready not released after read");

  property p_bank_decode;
    @(posedge mclk_in) disable iff (!reset_n_in)
      in_done |-> (quadrature_bank_enable_n_out == !(a15 && a0 && !a14 && !ds_n && !external_cycle_strobe_n_n))
              && (inphase_bank_enable_n_out == !(a15 && !a0 && !a14 && !ds_n && !external_cycle_strobe_n_n))
              && (low_byte_clear_out == !(inphase_bank_enable_n_out
                                          && quadrature_bank_enable_n_out));
  endproperty
  a_bank_decode: assert property (p_bank_decode)
    else $error("bank read decode wrong");

  property p_idle;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (state == iqcap_pkg::IQCAP_ST_IDLE)
        |-> sample_write_select_n_out && !host_address_enable_out && capture_ready_n_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle outputs wrong");

  c_full_capture: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == iqcap_pkg::IQCAP_ST_FLUSH ##1 state == iqcap_pkg::IQCAP_ST_DONE);
  c_read_q: cover property (@(posedge mclk_in) disable iff (!reset_n_in) read_q);
  c_read_i: cover property (@(posedge mclk_in) disable iff (!reset_n_in) read_i);
  c_retrigger: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == iqcap_pkg::IQCAP_ST_RUN ##1 state == iqcap_pkg::IQCAP_ST_ARMED);
endmodule // iqcap_sequencer
`default_nettype wire

// *** testbench/iqcap_dsp_model.sv ***
`default_nettype none
module iqcap_dsp_model #(
  parameter int READ_CYCLES = 4
) (
  input  wire logic mclk_in,
  input  wire logic rd_go_in,
  input  wire logic rd_odd_in,
  input  wire logic rd_miss_in,
  output logic      a15_out,
  output logic      a14_out,
  output logic      a0_out,
  output logic      ds_n_out,
  output logic      external_cycle_strobe_n_n_out,
  output logic      busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int hold = 0;

  initial begin
    a15_out = 1'b0;
    a14_out = 1'b1;
    a0_out = 1'b0;
    ds_n_out = 1'b1;
    external_cycle_strobe_n_n_out = 1'b1;
    busy_out = 1'b0;
  end

  // Address wanders outside reads so a stale decode cannot pass
  always @(posedge mclk_in) begin
    if (hold > 1) begin
      hold <= hold - 1;
    end else if (hold == 1) begin
      hold <= 0;
      ds_n_out <= 1'b1;
      external_cycle_strobe_n_n_out <= 1'b1;
      busy_out <= 1'b0;
    end else if (rd_go_in) begin
      a15_out <= 1'b1;
      a14_out <= rd_miss_in;
      a0_out <= rd_odd_in;
      ds_n_out <= 1'b0;
      external_cycle_strobe_n_n_out <= 1'b0;
      busy_out <= 1'b1;
      hold <= READ_CYCLES;
    end else begin
      a15_out <= ~a15_out;
      a14_out <= ~a14_out;
      a0_out <= ~a0_out;
    end
  end
endmodule // iqcap_dsp_model
`default_nettype wire

// *** testbench/test_iq_capture_sequencer.sv ***
`default_nettype none
module test_iq_capture_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        capture_trigger_n_n = 1'b1;
  logic [7:0]  adc_i = 8'h00;
  wire logic [7:0] adc_q = adc_i ^ 8'h5a;
  logic        rd_go = 1'b0, rd_odd = 1'b0, rd_miss = 1'b0, adc_ph = 1'b0;
  logic        a15, a14, a0, ds_n, external_cycle_strobe_n_n, rd_busy;
  logic        sclk, ien_n, qen_n, wsel_n, host_en, ready_n, low_byte, carry;
  logic [11:0] addr, prev_addr;
  logic [7:0]  ram_i, ram_q, off_i;
  logic        prev_wsel = 1'b1, prev_sclk = 1'b1, flush_seen = 1'b0;
  int          mismatches = 0, cmp_count = 0, cycles = 0, steps = 0;

  iqcap_dsp_model u_dsp (.mclk_in(mclk_in), .rd_go_in(rd_go), .rd_odd_in(rd_odd),
    .rd_miss_in(rd_miss), .a15_out(a15), .a14_out(a14), .a0_out(a0), .ds_n_out(ds_n),
    .external_cycle_strobe_n_n_out(external_cycle_strobe_n_n), .busy_out(rd_busy));

  iqcap_sequencer u_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .capture_trigger_n_in(capture_trigger_n_n), .adc_inphase_in(adc_i), .adc_quadrature_in(adc_q),
    .host_addr_a15_in(a15), .host_addr_a14_in(a14), .host_addr_a0_in(a0),
    .data_space_select_n_in(ds_n), .external_cycle_strobe_n_in(external_cycle_strobe_n_n),
    .sample_clock_out(sclk), .inphase_bank_enable_n_out(ien_n),
    .quadrature_bank_enable_n_out(qen_n), .sample_write_select_n_out(wsel_n),
    .host_address_enable_out(host_en), .capture_ready_n_out(ready_n),
    .low_byte_clear_out(low_byte), .counter_terminal_carry_out(carry),
    .ram_address_out(addr), .ram_inphase_data_out(ram_i), .ram_quadrature_data_out(ram_q));

  initial begin
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic bad(input string msg);
    mismatches++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  // Ramp steps once per two clocks, wraps through the full signed range
  always @(posedge mclk_in) begin
    adc_ph <= ~adc_ph;
    if (adc_ph) adc_i <= adc_i + 8'h01;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad("timeout");
      complete_run();
    end
  end

  always @(posedge mclk_in) begin
    #1;
    if (reset_n_in) begin
      cmp_count++;
      if (!wsel_n) begin
        if (ien_n !== sclk || qen_n !== sclk) bad("bank enable off sample clock");
        if (capture_trigger_n_n && !carry && !prev_wsel && addr != 0 && sclk === prev_sclk) bad("sclk stall");
        if (addr != 0 && ram_q !== (ram_i ^ 8'h5a)) bad("bank bytes out of pair");
        if (addr == 12'h001) off_i = ram_i - 8'h01;
        else if (addr > 1 && ram_i !== off_i + addr[7:0]) bad("byte not from prior cycle");
        if (addr == prev_addr + 12'h001) steps++;
        else if (addr == 0) steps = 0;
        else if (addr !== prev_addr) bad("address skipped");
        if (addr == 12'hfff && !ien_n) flush_seen = 1'b1;
      end else begin
        if (!prev_wsel && (steps != 4095 || !flush_seen)) bad("capture cut short");
        if (!prev_wsel && (host_en !== 1'b0 || ready_n !== 1'b0)) bad("end state");
        if (sclk !== 1'b1) bad("sample clock not parked high");
        flush_seen = 1'b0;
      end
      prev_addr = addr;
      prev_wsel = wsel_n;
      prev_sclk = sclk;
    end
  end

  task automatic check_idle;
    cmp_count++;
    if (wsel_n !== 1'b1 || host_en !== 1'b0 || ready_n !== 1'b1) bad("idle state");
    if (ien_n !== 1'b1 || qen_n !== 1'b1 || low_byte !== 1'b0) bad("idle enables");
  endtask

  // Hit is whether the decode should open a bank at all
  task automatic do_read(input logic odd, input logic miss, input logic hit, input logic rdy);
    @(posedge mclk_in);
    rd_go <= 1'b1;
    rd_odd <= odd;
    rd_miss <= miss;
    @(posedge mclk_in);
    rd_go <= 1'b0;
    tick(2);
    cmp_count++;
    if (ien_n !== !(hit && !odd) || qen_n !== !(hit && odd)) bad("bank decode");
    if (low_byte !== hit) bad("low byte clear");
    tick(1);
    if (ready_n !== rdy) bad("ready flag after read");
    tick(6);
  endtask

  task automatic trigger(input int low_cycles);
    logic w0, r0;
    w0 = wsel_n;
    r0 = ready_n;
    @(posedge mclk_in);
    capture_trigger_n_n <= 1'b0;
    tick(2);
    cmp_count++;
    if (wsel_n !== w0 || ready_n !== r0) bad("trigger acted early");
    tick(1);
    if (wsel_n !== 1'b0 || host_en !== 1'b1 || ready_n !== 1'b1) bad("trigger answer");
    tick(2);
    repeat (low_cycles) begin
      tick(1);
      if (addr !== 12'h000 || carry !== 1'b0) bad("counter not held");
    end
    @(posedge mclk_in);
    capture_trigger_n_n <= 1'b1;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (wsel_n !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    cmp_count++;
    if (n == 9000) bad("capture never finished");
  endtask

  task automatic hold_ready(input int n);
    repeat (n) begin
      tick(1);
      if (ready_n !== 1'b0 || host_en !== 1'b0) bad("ready released without read");
    end
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    tick(2);
    check_idle();
    do_read(1'b0, 1'b0, 1'b0, 1'b1);
    trigger(8);
    wait_done();
    hold_ready(40);
    do_read(1'b0, 1'b1, 1'b0, 1'b0);
    trigger(8);
    tick(1000);
    trigger(3);
    wait_done();
    do_read(1'b0, 1'b0, 1'b1, 1'b1);
    do_read(1'b1, 1'b0, 1'b1, 1'b1);
    complete_run();
  end
endmodule // test_iq_capture_sequencer
`default_nettype wire
